// ==== dv/audio_serial_mulaw_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// port checks
module audio_serial_mulaw_properties (
  input logic        ref_clk_i,
  input logic        rst_i,
  input logic [15:0] addr_i,
  input logic        wr_en_i,
  input logic        rd_en_i,
  input logic [7:0]  wdata_i,
  input logic [7:0]  rdata_o,
  input logic        sck_oe_n_o,
  input logic        ws_oe_n_o,
  input logic        tx_sd_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire cfg_wr = wr_en_i && addr_i == 16'hdf40;
  reset_idle_a: assert property ($fell(rst_i) |-> sck_oe_n_o && !tx_sd_o && rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  pins_paired_a: assert property (sck_oe_n_o == ws_oe_n_o)
    else $error("clock and select enables differ");
  disable_off_a: assert property (cfg_wr && !wdata_i[0] |=> sck_oe_n_o)
    else $error("pins driven while disabled");
  master_on_a: assert property (cfg_wr && wdata_i[1:0] == 2'b11 |=> !sck_oe_n_o)
    else $error("master does not drive pins");
  slave_off_a: assert property (cfg_wr && wdata_i[1:0] == 2'b01 |=> sck_oe_n_o)
    else $error("slave drives pins");
  unmapped_zero_a: assert property (rd_en_i && (addr_i < 16'hdf40 || addr_i > 16'hdf48) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_en_i |=> $stable(rdata_o))
    else $error("read data moved without read");
  cfg_readback_a: assert property (cfg_wr ##2 (rd_en_i && addr_i == 16'hdf40) |=> rdata_o == $past(wdata_i, 3))
    else $error("config readback wrong");
endmodule
bind audio_serial_mulaw audio_serial_mulaw_properties chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sck_oe_n_o(sck_oe_n_o),
  .ws_oe_n_o(ws_oe_n_o), .tx_sd_o(tx_sd_o));

// ==== dv/audio_serial_mulaw_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================
// register-level bench
module audio_serial_mulaw_tb_top;
  reg         ref_clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         wr_en_i = 1'b0;
  reg         rd_en_i = 1'b0;
  reg  [15:0] addr_i = 16'h0000;
  reg  [7:0]  wdata_i = 8'h00;
  reg  [7:0]  d;
  reg  [7:0]  hi;
  reg  [15:0] x;
  wire [7:0]  rdata_o;
  wire [15:0] tx_left;
  wire        sck_o, sck_oe_n_o, ws_o, ws_oe_n_o, tx_sd_o, far_sck, far_ws, far_sd;
  integer     err_count = 0, comparisons = 0, cycles = 0, i;
  wire        sck_w = sck_oe_n_o ? far_sck : sck_o;
  wire        ws_w = ws_oe_n_o ? far_ws : ws_o;
  always #20 ref_clk_i = ~ref_clk_i;
  audio_serial_mulaw dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .ws_i(ws_w), .ws_o(ws_o), .ws_oe_n_o(ws_oe_n_o), .rx_sd_i(far_sd), .tx_sd_o(tx_sd_o));
  i2s_far_end far (.tx_sd_i(tx_sd_o), .sck_o(far_sck), .ws_o(far_ws), .sd_o(far_sd), .tx_left_o(tx_left));
  // an idle cycle after each access keeps strobes from toggling twice in one step
  task wr(input [15:0] a, input [7:0] v);
    begin
      addr_i = a; wdata_i = v; wr_en_i = 1'b1;
      @(posedge ref_clk_i) #1 wr_en_i = 1'b0;
      @(posedge ref_clk_i) #1;
    end
  endtask
  task rd(input [15:0] a, output [7:0] v);
    begin
      addr_i = a; rd_en_i = 1'b1;
      @(posedge ref_clk_i) #1 rd_en_i = 1'b0;
      @(posedge ref_clk_i) #1 v = rdata_o;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  function [15:0] mu_e(input [7:0] c);
    reg [7:0]  u;
    reg [15:0] t;
    begin
      u = ~c;
      t = (({12'h000, u[3:0]} << 3) + 16'h0084) << u[6:4];
      mu_e = u[7] ? 16'h0084 - t : t - 16'h0084;
    end
  endfunction
  function [7:0] mu_c(input [15:0] s);
    reg [15:0] m;
    reg [2:0]  e;
    begin
      m = s[15] ? -s : s;
      if (m > 16'h7f7b) m = 16'h7f7b;
      m = m + 16'h0084;
      e = 3'h7;
      while (e > 0 && !m[e + 7]) e = e - 1;
      mu_c = ~{s[15], e, m[e + 3 +: 4]};
    end
  endfunction
  task end_of_test;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    rd(16'hdf40, d); chk(d, 8'h00);
    rd(16'hdf41, d); chk(d, 8'h78);
    rd(16'hdf46, d); chk(d, 8'h09);
    wr(16'hdf49, 8'hff); rd(16'hdf49, d); chk(d, 8'h00);
    wr(16'hdf40, 8'h20); rd(16'hdf40, d); chk(d, 8'h20);
    for (i = 0; i < 8; i = i + 1) begin
      wr(16'hdf43, {i[2:0], i[2:0], i[1:0]});
      rd(16'hdf43, hi); rd(16'hdf42, d);
      chk({hi, d}, mu_e({i[2:0], i[2:0], i[1:0]}));
    end
    wr(16'hdf40, 8'h10);
    for (i = 0; i < 8; i = i + 1) begin
      x = {i[2:0], {13{i[0]}}};
      wr(16'hdf42, x[7:0]); wr(16'hdf43, x[15:8]); rd(16'hdf43, d);
      chk(d, mu_c(x));
    end
    wr(16'hdf40, 8'h03);
    chk(sck_oe_n_o, 1'b0);
    chk(ws_oe_n_o, 1'b0);
    for (i = 0; i < 100 && sck_o !== 1'b1; i = i + 1) @(posedge ref_clk_i);
    chk(sck_o, 1'b1);
    wr(16'hdf40, 8'h34);
    chk(sck_oe_n_o, 1'b1);
    wr(16'hdf40, 8'h35);
    wr(16'hdf43, 8'h9c); rd(16'hdf45, d); chk(d[1], 1'b0);
    far.frame(16'h1234, 16'hbeef);
    @(posedge ref_clk_i) #1;
    chk(tx_left, mu_e(8'h9c));
    rd(16'hdf45, d); chk(d[1:0], 2'b11);
    rd(16'hdf43, d); chk(d, mu_c(16'h1234));
    rd(16'hdf45, d); chk(d[0], 1'b0);
    end_of_test;
  end
endmodule

// ==== dv/i2s_far_end.sv ====
`timescale 1ns/1ps
// ==========================================
// external serial master, one frame per call
module i2s_far_end (
  input  wire        tx_sd_i,
  output reg         sck_o,
  output reg         ws_o,
  output reg         sd_o,
  output reg  [15:0] tx_left_o
);
  integer    k;
  reg [31:0] bits;
  initial begin
    sck_o = 1'b0;
    ws_o = 1'b1;
    sd_o = 1'b0;
    tx_left_o = 16'h0000;
  end
  // clock stands low between frames; data toggles when not carrying bits
  task frame(input [15:0] l, input [15:0] r);
    begin
      bits = {l, r};
      for (k = 0; k < 34; k = k + 1) begin
        ws_o = (k >= 16 && k < 32);
        sd_o = (k >= 1 && k <= 32) ? bits[32 - k] : ~sd_o;
        #160 sck_o = 1'b1;
        if (k >= 1 && k <= 16) tx_left_o[16 - k] = tx_sd_i;
        #160 sck_o = 1'b0;
      end
      sd_o = ~sd_o;
    end
  endtask
endmodule

// ==== hdl/audio_serial_mulaw.v ====
`timescale 1ns/1ps
// Behaviour
// - enabled with expand set: high-byte writes expand to 16-bit samples for transmit.
// - enabled with compress set: received samples compress to 8 bits into high byte.
// - disabled, expand only: high-byte write yields expanded sample one cycle later.
// - disabled, compress only: 16-bit written sample yields compressed byte one cycle later.
// - registers sit in external data space from 0xdf40 to 0xdf48.
// - reset values describe 16-bit stereo at 44.1 kHz.
// - interface enable is clear after reset.
// - config bit 5 selects expansion.
// - config bit 4 selects compression.
// - config bit 3 set: each transmit sample sent in the left channel only; the right channel carries zeros.
// - config bit 2 set: receiver drops right-channel words.
// - config bit 1 clear: slave on pin clocks; set: device drives clock and select.
// - config bit 0 enables serial interface; clear gives stand-alone converter.
// - high-byte write clears transmit request; high-byte read clears receive request.
`include "audio_serial_regs.vh"
module audio_serial_mulaw (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [15:0] addr_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  input  wire [7:0]  wdata_i,
  output reg  [7:0]  rdata_o,
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe_n_o,
  input  wire        ws_i,
  output wire        ws_o,
  output wire        ws_oe_n_o,
  input  wire        rx_sd_i,
  output reg         tx_sd_o
);

  // ==========================================
  // mu-law helpers
  function [7:0] mu_compress;
    input [15:0] s;
    reg [15:0] mag;
    reg [2:0]  ex;
    reg [3:0]  man;
    integer    i;
    begin
      mag = s[15] ? (~s + 16'h0001) : s;
      if (mag > `AS_MU_CLIP) mag = `AS_MU_CLIP;
      mag = mag + `AS_MU_BIAS;
      ex = 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        if (mag[i+7]) ex = i[2:0];
      end
      man = mag[ex+3 +: 4];
      mu_compress = ~{s[15], ex, man};
    end
  endfunction

  function [15:0] mu_expand;
    input [7:0] c;
    reg [7:0]  u;
    reg [15:0] t;
    begin
      u = ~c;
      t = ({8'h00, 1'b0, u[3:0], 3'h0} + `AS_MU_BIAS) << u[6:4];
      mu_expand = u[7] ? (`AS_MU_BIAS - t) : (t - `AS_MU_BIAS);
    end
  endfunction

  function is_addr;
    input [15:0] a;
    input [15:0] ref_a;
    begin
      is_addr = (a == ref_a);
    end
  endfunction

  // ==========================================
  // registers
  reg  [7:0]  config_r;
  reg  [7:0]  config1;
  reg  [7:0]  sck_half;
  reg  [7:0]  data_lo;
  reg  [7:0]  data_hi;
  reg  [7:0]  wr_lo;
  reg         lo_written;
  reg  [15:0] tx_buf;
  reg         tx_full;
  reg         tx_req;
  reg         rx_req;
  reg         rx_lr;
  reg         tx_lr;
  reg         conv_pend;
  reg  [7:0]  conv_byte;

  wire enab     = config_r[`AS_CFG_ENABLE];
  wire master   = config_r[`AS_CFG_MASTER];
  wire expand   = config_r[`AS_CFG_EXPAND];
  wire compress = config_r[`AS_CFG_COMPRESS];
  wire wr_hi    = wr_en_i & is_addr(addr_i, `AS_ADDR_HIGH);
  wire wr_lo_s  = wr_en_i & is_addr(addr_i, `AS_ADDR_LOW);
  wire rd_hi    = rd_en_i & is_addr(addr_i, `AS_ADDR_HIGH);
  wire [15:0] wr_sample = {wdata_i, lo_written ? wr_lo : 8'h00};

  // ==========================================
  // pin synchronisers and clock selection
  reg  [1:0] sck_sync;
  reg  [1:0] ws_sync;
  reg  [1:0] sd_sync;
  reg        m_sck;
  reg        m_ws;
  reg  [7:0] div_cnt;
  reg  [3:0] m_bits;
  reg        sck_prev;
  reg        ws_prev;
  reg  [4:0] rx_cnt;
  reg  [15:0] rx_shift;
  reg  [15:0] tx_shift;

  wire sck_now  = master ? m_sck : sck_sync[1];
  wire ws_now   = master ? m_ws  : ws_sync[1];
  wire sck_rise = enab & sck_now & ~sck_prev;
  wire sck_fall = enab & ~sck_now & sck_prev;
  wire ws_edge  = sck_rise & (ws_now != ws_prev);
  wire [15:0] rx_word = (rx_cnt < `AS_WORD_BITS) ? {rx_shift[14:0], sd_sync[1]} : rx_shift;
  wire rx_keep  = ~(config_r[`AS_CFG_RX_MONO] & ws_prev);
  wire tx_fetch = ws_edge & (~ws_now | ~config_r[`AS_CFG_TX_MONO]);

  assign sck_o      = m_sck;
  assign ws_o       = m_ws;
  assign sck_oe_n_o = ~(enab & master);
  assign ws_oe_n_o  = ~(enab & master);

  always @(posedge ref_clk_i) begin
    sck_sync <= {sck_sync[0], sck_i};
    ws_sync  <= {ws_sync[0], ws_i};
    sd_sync  <= {sd_sync[0], rx_sd_i};
  end

  // ==========================================
  // master clock and word select generator
  // integer divider only; sample rate is clock / (64 * half period)
  always @(posedge ref_clk_i) begin
    if (rst_i || !(enab && master)) begin
      div_cnt <= 8'h00;
      m_sck   <= 1'b0;
      m_ws    <= 1'b0;
      m_bits  <= 4'h0;
    end else if (div_cnt + 8'h01 >= sck_half) begin
      div_cnt <= 8'h00;
      m_sck   <= ~m_sck;
      if (m_sck) begin
        m_bits <= m_bits + 4'h1;
        if (m_bits == `AS_LAST_BIT) m_ws <= ~m_ws;
      end
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ==========================================
  // serial shifters
  always @(posedge ref_clk_i) begin
    if (rst_i || !enab) begin
      // track the pins while idle so enabling does not miss the first word edge
      sck_prev <= sck_now;
      ws_prev  <= ws_now;
      rx_cnt   <= 5'h00;
      rx_shift <= 16'h0000;
      tx_shift <= 16'h0000;
      tx_sd_o  <= 1'b0;
      tx_lr    <= 1'b0;
    end else begin
      sck_prev <= sck_now;
      if (sck_rise) begin
        ws_prev <= ws_now;
        if (ws_edge) begin
          rx_cnt   <= 5'h00;
          rx_shift <= 16'h0000;
          tx_lr    <= ws_now;
          // empty buffer sends zeros rather than stale data
          if (config_r[`AS_CFG_TX_MONO] && ws_now)
            tx_shift <= tx_shift;
          else
            tx_shift <= tx_full ? tx_buf : 16'h0000;
        end else if (rx_cnt < `AS_WORD_BITS) begin
          rx_cnt   <= rx_cnt + 5'h01;
          rx_shift <= rx_word;
        end
      end
      if (sck_fall) begin
        tx_sd_o  <= tx_shift[15];
        if (!(config_r[`AS_CFG_TX_MONO] && tx_lr))
          tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // ==========================================
  // register file, buffers and converter
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      config_r   <= `AS_RST_CONFIG;
      config1    <= `AS_RST_CONFIG1;
      sck_half   <= `AS_RST_SCK_HALF;
      data_lo    <= 8'h00;
      data_hi    <= 8'h00;
      wr_lo      <= 8'h00;
      lo_written <= 1'b0;
      tx_buf     <= 16'h0000;
      tx_full    <= 1'b0;
      tx_req     <= 1'b0;
      rx_req     <= 1'b0;
      rx_lr      <= 1'b0;
      conv_pend  <= 1'b0;
      conv_byte  <= 8'h00;
    end else begin
      conv_pend <= 1'b0;
      if (wr_en_i && is_addr(addr_i, `AS_ADDR_CONFIG))   config_r <= wdata_i;
      if (wr_en_i && is_addr(addr_i, `AS_ADDR_CONFIG1))  config1  <= wdata_i;
      if (wr_en_i && is_addr(addr_i, `AS_ADDR_SCK_HALF)) sck_half <= wdata_i;
      if (wr_lo_s) begin
        wr_lo      <= wdata_i;
        lo_written <= 1'b1;
        if (!enab) data_lo <= wdata_i;
      end
      if (rd_hi) rx_req <= 1'b0;
      if (tx_fetch) begin
        tx_full <= 1'b0;
        tx_req  <= 1'b1;
      end
      if (wr_hi) begin
        lo_written <= 1'b0;
        // a fetch in the same cycle sets the request again: set wins
        if (!tx_fetch) tx_req <= 1'b0;
        tx_full    <= enab;
        tx_buf     <= (enab && expand) ? mu_expand(wdata_i) : wr_sample;
        if (!enab) begin
          conv_pend <= 1'b1;
          conv_byte <= wdata_i;
          data_hi   <= wdata_i;
        end
      end
      if (conv_pend) begin
        if (expand && !compress) begin
          {data_hi, data_lo} <= mu_expand(conv_byte);
        end else if (compress && !expand) begin
          data_hi <= mu_compress({conv_byte, data_lo});
        end
      end
      if (ws_edge && rx_keep) begin
        rx_req <= 1'b1;  // a word landing with the read still sets the flag
        rx_lr  <= ws_prev;
        if (compress) begin
          data_hi <= mu_compress(rx_word);
          data_lo <= 8'h00;
        end else begin
          {data_hi, data_lo} <= rx_word;
        end
      end
    end
  end

  // ==========================================
  // read port, one cycle latency
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        `AS_ADDR_CONFIG:   rdata_o <= config_r;
        `AS_ADDR_CONFIG1:  rdata_o <= config1;
        `AS_ADDR_LOW:      rdata_o <= data_lo;
        `AS_ADDR_HIGH:     rdata_o <= data_hi;
        `AS_ADDR_STATE:    rdata_o <= {3'h0, tx_full, tx_lr, rx_lr, tx_req, rx_req};
        `AS_ADDR_SCK_HALF: rdata_o <= sck_half;
        default:           rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ==== hdl/audio_serial_regs.vh ====
`ifndef AUDIO_SERIAL_REGS_VH
`define AUDIO_SERIAL_REGS_VH
// ==========================================
// register addresses (external data space)
`define AS_ADDR_CONFIG    16'hdf40
`define AS_ADDR_CONFIG1   16'hdf41
`define AS_ADDR_LOW       16'hdf42
`define AS_ADDR_HIGH      16'hdf43
`define AS_ADDR_WCOUNT    16'hdf44
`define AS_ADDR_STATE     16'hdf45
`define AS_ADDR_SCK_HALF  16'hdf46
`define AS_ADDR_LAST      16'hdf48
// ==========================================
// config field positions
`define AS_CFG_TX_IRQ_EN  7
`define AS_CFG_RX_IRQ_EN  6
`define AS_CFG_EXPAND     5
`define AS_CFG_COMPRESS   4
`define AS_CFG_TX_MONO    3
`define AS_CFG_RX_MONO    2
`define AS_CFG_MASTER     1
`define AS_CFG_ENABLE     0
// ==========================================
// reset values: 16-bit stereo, 44.1 kHz
`define AS_RST_CONFIG     8'h00
`define AS_RST_CONFIG1    8'h78
`define AS_RST_SCK_HALF   8'h09
`define AS_WORD_BITS      5'h10
`define AS_LAST_BIT       4'hf
// ==========================================
// mu-law constants
`define AS_MU_BIAS        16'h0084
`define AS_MU_CLIP        16'h7f7b
`endif
